/* File: design/fps_pkg.sv */
//
// Overview of operation
// - Quasi-resonant cycle starts after demag then valley.
// - At frequency ceiling enter discontinuous valley skipping.
// - Frequency reduction: oscillator, 25 kHz floor, valleys.
// - Burst pulses never slower than 25 kHz.
// - Sample mains every millisecond by grounding pin.
// - Switching allowed only after brownin seen.
// - 30 ms below brownout stops switching.
// - Threshold crossing between samples proves mains present.
// - Pause sampling 6 ms, 97 ms in burst.
// - No slope for 28 ms: discharge X-capacitor.
// - Aux measurement meaning depends on cycle section.
// - Protection stops switching, then restart or latch.
// - Regulate supply while stopped, except in aux-open.
// - Temperature input qualified 2-4 ms, then latch.
// - Overcurrent cycle-by-cycle after blanking, no stop.
// - Overvoltage latches after four consecutive faulty pulses.
// - Protect input mid-band clocks delay counter by ms.
// - Above high overpower reference ends gate pulse.
// - Above low reference runs counter; 200 ms restarts.
// - Startup 100 % with 40 ms; regulated 150 %, 200 ms.
// - Overpower with undervoltage protects at once.
// - Safe restart waits 800 ms, rechecks brownin.
// - On-time beyond 55 us forces safe restart.
//
package fps_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned MS_CYC          = CLK_HZ / 1000;
  localparam int unsigned FMIN_HZ         = 25_000;
  localparam int unsigned FMIN_PER_CYC    = CLK_HZ / FMIN_HZ;
  localparam int unsigned MAX_ON_NS       = 55_000;
  localparam int unsigned CLK_PER_NS      = 1_000_000_000 / CLK_HZ;
  localparam int unsigned MAX_ON_CYC      = MAX_ON_NS / CLK_PER_NS;
  localparam int unsigned BROWNOUT_MS     = 30;
  localparam int unsigned PAUSE_MS        = 6;
  localparam int unsigned PAUSE_BURST_MS  = 97;
  localparam int unsigned DISCONNECT_MS   = 28;
  localparam int unsigned TEMP_MS         = 3;
  localparam int unsigned OVP_PULSES      = 4;
  localparam int unsigned OPP_START_MS    = 40;
  localparam int unsigned OPP_RUN_MS      = 200;
  localparam int unsigned RESTART_MS      = 800;
  localparam int unsigned BLANK_CYC       = 8;
  localparam int unsigned MS_W            = 10;
  localparam int unsigned CYC_W           = 16;

  // ---------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FPS_QR    = 4'h1,
    FPS_DCM   = 4'h2,
    FPS_FREQ  = 4'h4,
    FPS_BURST = 4'h8
  } fps_mode_t;

  typedef enum logic [5:0] {
    FPS_WAIT_MAINS = 6'h01,
    FPS_RUN        = 6'h02,
    FPS_RESTART    = 6'h04,
    FPS_LATCHED    = 6'h08,
    FPS_BROWNOUT   = 6'h10,
    FPS_AUX_OPEN   = 6'h20
  } fps_state_t;

  typedef enum logic [3:0] {
    FPS_SEC_ON    = 4'h1,
    FPS_SEC_DEMAG = 4'h2,
    FPS_SEC_VALLEY= 4'h4,
    FPS_SEC_IDLE  = 4'h8
  } fps_sec_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic demag;
    logic valley;
    logic aux_ovp;
    logic aux_open;
    logic ocp;
    logic opc_high;
    logic opp_low;
    logic opp_low_100;
    logic supply_undervoltage_lock;
    logic temp_int;
    logic prot_low;
    logic prot_mid;
    logic ctrl_regulated;
    logic f_at_max;
    logic ctrl_burst;
    logic ctrl_freq_red;
  } fps_cmp_t;

  // Digitised mains sample
  typedef struct packed {
    logic valid;
    logic above_brownin;
    logic above_high;
    logic above_brownout;
  } fps_mains_t;

endpackage

/* File: design/fps_supervisor.sv */
`timescale 1ns/1ps
module fps_supervisor #(
  parameter int unsigned MS_CYC     = fps_pkg::MS_CYC,
  parameter int unsigned MAX_ON_CYC = fps_pkg::MAX_ON_CYC,
  parameter int unsigned FMIN_CYC   = fps_pkg::FMIN_PER_CYC,
  parameter int unsigned BLANK_CYC  = fps_pkg::BLANK_CYC
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Analog front end
  input  wire fps_pkg::fps_cmp_t   cmp_i,
  input  wire fps_pkg::fps_mains_t mains_i,
  input  wire logic             ton_req_i,
  input  wire logic [15:0]      osc_period_i,
  // Power stage
  output logic                  gate_o,
  output logic                  mains_sense_pin_pull_o,
  output logic                  xcap_discharge_o,
  output logic                  vcc_regulate_o,
  output logic                  prot_enable_o,
  // Status
  output fps_pkg::fps_mode_t    mode_o,
  output fps_pkg::fps_sec_t     section_o,
  output logic                  brownout_o,
  output logic                  latched_o,
  output logic                  restart_o,
  output logic                  ocp_limit_o
);

  // ---------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------
  logic [fps_pkg::CYC_W-1:0] ms_div;
  logic                      ms_tick;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ms_div  <= '0;
      ms_tick <= 1'b0;
    end else if (ce_i) begin
      ms_tick <= (ms_div == fps_pkg::CYC_W'(MS_CYC - 1));
      if (ms_div == fps_pkg::CYC_W'(MS_CYC - 1)) begin
        ms_div <= '0;
      end else begin
        ms_div <= ms_div + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mains monitor
  // ---------------------------------------------------------------
  fps_pkg::fps_state_t    state;
  logic [fps_pkg::MS_W-1:0] pause_cnt;
  logic [fps_pkg::MS_W-1:0] bo_cnt;
  logic [fps_pkg::MS_W-1:0] slope_cnt;
  logic                   prev_bi;
  logic                   prev_hi;
  logic                   mains_ok;
  logic                   disconnected;
  logic                   slope;

  assign slope = mains_i.valid &&
                 ((mains_i.above_brownin && !prev_bi) || (mains_i.above_high && !prev_hi));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mains_sense_pin_pull_o <= 1'b0;
      pause_cnt              <= '0;
      prev_bi                <= 1'b0;
      prev_hi                <= 1'b0;
    end else if (ce_i) begin
      if (disconnected) begin
        mains_sense_pin_pull_o <= 1'b1;
      end else if (ms_tick && pause_cnt == '0) begin
        mains_sense_pin_pull_o <= 1'b1;
      end else if (mains_i.valid) begin
        mains_sense_pin_pull_o <= 1'b0;
      end
      if (mains_i.valid) begin
        prev_bi <= mains_i.above_brownin;
        prev_hi <= mains_i.above_high;
      end
      if (slope) begin
        pause_cnt <= (mode_o == fps_pkg::FPS_BURST) ? fps_pkg::MS_W'(fps_pkg::PAUSE_BURST_MS)
                                                    : fps_pkg::MS_W'(fps_pkg::PAUSE_MS);
      end else if (ms_tick && pause_cnt != '0) begin
        pause_cnt <= pause_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bo_cnt     <= '0;
      brownout_o <= 1'b0;
      mains_ok   <= 1'b0;
    end else if (ce_i) begin
      if (mains_i.valid && mains_i.above_brownin) begin
        mains_ok   <= 1'b1;
        brownout_o <= 1'b0;
        bo_cnt     <= '0;
      end else if (mains_i.valid && mains_i.above_brownout) begin
        bo_cnt <= '0;
      end else if (ms_tick && pause_cnt == '0) begin
        if (bo_cnt >= fps_pkg::MS_W'(fps_pkg::BROWNOUT_MS - 1)) begin
          brownout_o <= 1'b1;
          mains_ok   <= 1'b0;
        end else begin
          bo_cnt <= bo_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slope_cnt    <= '0;
      disconnected <= 1'b0;
    end else if (ce_i) begin
      if (slope) begin
        slope_cnt    <= '0;
        disconnected <= 1'b0;
      end else if (ms_tick) begin
        if (slope_cnt >= fps_pkg::MS_W'(fps_pkg::DISCONNECT_MS - 1)) begin
          disconnected <= 1'b1;
        end else begin
          slope_cnt <= slope_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      xcap_discharge_o <= 1'b0;
    end else if (ce_i) begin
      xcap_discharge_o <= disconnected;
    end
  end

  // ---------------------------------------------------------------
  // Switching cycle and sections
  // ---------------------------------------------------------------
  logic [fps_pkg::CYC_W-1:0] on_cnt;
  logic [fps_pkg::CYC_W-1:0] per_cnt;
  logic                      running;
  logic                      gate_start;
  logic                      gate_end;
  logic                      max_on;
  logic                      valley_ok;
  logic                      timer_ok;

  assign running   = (state == fps_pkg::FPS_RUN);
  assign max_on    = gate_o && on_cnt >= fps_pkg::CYC_W'(MAX_ON_CYC);
  // The first pulse after reset starts from idle on any valley
  assign valley_ok = cmp_i.valley &&
                     (section_o == fps_pkg::FPS_SEC_VALLEY || section_o == fps_pkg::FPS_SEC_IDLE);
  assign timer_ok  = per_cnt >= fps_pkg::CYC_W'(FMIN_CYC - 1);
  // Oscillator period bounded by the floor frequency
  always_comb begin
    gate_start = 1'b0;
    case (mode_o)
      fps_pkg::FPS_QR:    gate_start = valley_ok;
      fps_pkg::FPS_DCM:   gate_start = valley_ok && !cmp_i.f_at_max;
      fps_pkg::FPS_FREQ:  gate_start = valley_ok &&
                                       (per_cnt >= osc_period_i || timer_ok);
      fps_pkg::FPS_BURST: gate_start = (valley_ok || timer_ok) && ton_req_i;
      default:            gate_start = 1'b0;
    endcase
    gate_start = gate_start && running && !gate_o;
  end

  // Peak limits end the pulse; overcurrent only after blanking
  // Only a pulse in progress can end; a stale on count must not block the next start
  assign gate_end = gate_o && (max_on || cmp_i.opc_high ||
                    (cmp_i.ocp && on_cnt >= fps_pkg::CYC_W'(BLANK_CYC)) ||
                    (cmp_i.ctrl_burst && mode_o == fps_pkg::FPS_FREQ && cmp_i.opp_low_100));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gate_o      <= 1'b0;
      on_cnt      <= '0;
      per_cnt     <= '0;
      ocp_limit_o <= 1'b0;
    end else if (ce_i) begin
      if (!running || gate_end || brownout_o) begin
        gate_o      <= 1'b0;
        ocp_limit_o <= running && cmp_i.ocp && on_cnt >= fps_pkg::CYC_W'(BLANK_CYC);
      end else if (gate_start) begin
        gate_o  <= 1'b1;
        on_cnt  <= '0;
        per_cnt <= '0;
      end
      if (gate_o) begin
        on_cnt <= on_cnt + 1'b1;
      end
      if (!gate_start && per_cnt != '1) begin
        per_cnt <= per_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      section_o <= fps_pkg::FPS_SEC_IDLE;
    end else if (ce_i) begin
      case (section_o)
        fps_pkg::FPS_SEC_ON:     if (!gate_o) section_o <= fps_pkg::FPS_SEC_DEMAG;
        fps_pkg::FPS_SEC_DEMAG:  if (cmp_i.demag) section_o <= fps_pkg::FPS_SEC_VALLEY;
        fps_pkg::FPS_SEC_VALLEY: if (gate_o) section_o <= fps_pkg::FPS_SEC_ON;
        fps_pkg::FPS_SEC_IDLE:   if (gate_o) section_o <= fps_pkg::FPS_SEC_ON;
        default:                 section_o <= fps_pkg::FPS_SEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_o <= fps_pkg::FPS_QR;
    end else if (ce_i) begin
      if (cmp_i.ctrl_burst) begin
        mode_o <= fps_pkg::FPS_BURST;
      end else if (cmp_i.ctrl_freq_red) begin
        mode_o <= fps_pkg::FPS_FREQ;
      end else if (cmp_i.f_at_max) begin
        mode_o <= fps_pkg::FPS_DCM;
      end else begin
        mode_o <= fps_pkg::FPS_QR;
      end
    end
  end

  // ---------------------------------------------------------------
  // Protection counters
  // ---------------------------------------------------------------
  logic [2:0]               ovp_cnt;
  logic [fps_pkg::MS_W-1:0] opp_cnt;
  logic [fps_pkg::MS_W-1:0] temp_cnt;
  logic                     regulated;
  logic                     opp_hit;
  logic                     ovp_trip;
  logic                     temp_trip;
  logic                     opp_trip;

  assign opp_hit  = regulated ? cmp_i.opp_low : cmp_i.opp_low_100;
  assign ovp_trip = ovp_cnt >= 3'(fps_pkg::OVP_PULSES);
  assign temp_trip = temp_cnt >= fps_pkg::MS_W'(fps_pkg::TEMP_MS);
  assign opp_trip = (opp_hit && cmp_i.supply_undervoltage_lock) ||
                    opp_cnt >= (regulated ? fps_pkg::MS_W'(fps_pkg::OPP_RUN_MS)
                                          : fps_pkg::MS_W'(fps_pkg::OPP_START_MS));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      regulated <= 1'b0;
    end else if (ce_i) begin
      if (!running) begin
        regulated <= 1'b0;
      end else if (cmp_i.ctrl_regulated) begin
        regulated <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ovp_cnt <= '0;
    end else if (ce_i) begin
      if (!running) begin
        ovp_cnt <= '0;
      end else if (cmp_i.prot_mid ? ms_tick : (section_o == fps_pkg::FPS_SEC_DEMAG && cmp_i.demag)) begin
        ovp_cnt <= cmp_i.aux_ovp ? ovp_cnt + 1'b1 : '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      opp_cnt <= '0;
    end else if (ce_i) begin
      if (!running || !opp_hit) begin
        opp_cnt <= '0;
      end else if (ms_tick) begin
        opp_cnt <= opp_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      temp_cnt <= '0;
    end else if (ce_i) begin
      if (!(cmp_i.prot_low || cmp_i.prot_mid)) begin
        temp_cnt <= '0;
      end else if (ms_tick && !temp_trip) begin
        temp_cnt <= temp_cnt + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Protection state machine
  // ---------------------------------------------------------------
  logic [fps_pkg::MS_W-1:0] rs_cnt;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state  <= fps_pkg::FPS_WAIT_MAINS;
      rs_cnt <= '0;
    end else if (ce_i) begin
      case (state)
        fps_pkg::FPS_WAIT_MAINS: begin
          if (mains_ok && !cmp_i.supply_undervoltage_lock) state <= fps_pkg::FPS_RUN;
        end
        fps_pkg::FPS_RUN: begin
          if (cmp_i.temp_int || temp_trip || ovp_trip) begin
            state <= fps_pkg::FPS_LATCHED;
          end else if (max_on || opp_trip) begin
            state  <= fps_pkg::FPS_RESTART;
            rs_cnt <= '0;
          end else if (brownout_o) begin
            state <= fps_pkg::FPS_BROWNOUT;
          end else if (cmp_i.aux_open) begin
            state <= fps_pkg::FPS_AUX_OPEN;
          end else if (cmp_i.supply_undervoltage_lock) begin
            state <= fps_pkg::FPS_WAIT_MAINS;
          end
        end
        fps_pkg::FPS_RESTART: begin
          if (ms_tick && rs_cnt != '1) rs_cnt <= rs_cnt + 1'b1;
          if (rs_cnt >= fps_pkg::MS_W'(fps_pkg::RESTART_MS) && mains_ok) begin
            state <= fps_pkg::FPS_WAIT_MAINS;
          end
        end
        fps_pkg::FPS_LATCHED:  state <= fps_pkg::FPS_LATCHED;
        fps_pkg::FPS_BROWNOUT: if (mains_ok) state <= fps_pkg::FPS_WAIT_MAINS;
        fps_pkg::FPS_AUX_OPEN: if (!cmp_i.aux_open) state <= fps_pkg::FPS_WAIT_MAINS;
        default:               state <= fps_pkg::FPS_WAIT_MAINS;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vcc_regulate_o <= 1'b1;
      prot_enable_o  <= 1'b0;
      latched_o      <= 1'b0;
      restart_o      <= 1'b0;
    end else if (ce_i) begin
      vcc_regulate_o <= (state != fps_pkg::FPS_AUX_OPEN) && !(running && regulated);
      prot_enable_o  <= (state == fps_pkg::FPS_WAIT_MAINS && mains_ok) || running;
      latched_o      <= state == fps_pkg::FPS_LATCHED;
      restart_o      <= state == fps_pkg::FPS_RESTART;
    end
  end

endmodule

/* File: dv/fps_supervisor_asserts.sv */
`timescale 1ns/1ps
module fps_supervisor_asserts #(
  parameter int unsigned MAX_ON_CYC = fps_pkg::MAX_ON_CYC
) (
  // Clock and reset
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  // Inputs
  input wire fps_pkg::fps_cmp_t cmp_i,
  // Outputs
  input wire logic              gate_o,
  input wire logic              mains_sense_pin_pull_o,
  input wire logic              xcap_discharge_o,
  input wire logic              vcc_regulate_o,
  input wire logic              prot_enable_o,
  input wire logic              brownout_o,
  input wire logic              latched_o,
  input wire logic              restart_o
);
  int unsigned on_cnt;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Length of the present gate pulse
  always_ff @(posedge mclk_i) begin
    if (rst_i || !gate_o) begin
      on_cnt <= 0;
    end else if (ce_i) begin
      on_cnt <= on_cnt + 1;
    end
  end

  property p_latch_hold;
    latched_o |=> latched_o;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");
  property p_latch_off;
    latched_o && $past(latched_o) |-> !gate_o;
  endproperty
  a_latch_off: assert property (p_latch_off) else $error("gate while latched");
  property p_restart_off;
    restart_o && $past(restart_o) |-> !gate_o;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("gate in restart");
  property p_bo_off;
    brownout_o && $past(brownout_o) |-> !gate_o;
  endproperty
  a_bo_off: assert property (p_bo_off) else $error("gate in brownout");
  property p_xcap_pull;
    xcap_discharge_o && $past(xcap_discharge_o) |-> mains_sense_pin_pull_o;
  endproperty
  a_xcap_pull: assert property (p_xcap_pull) else $error("pin not held low");
  property p_latch_vcc;
    latched_o && $past(latched_o) |-> vcc_regulate_o;
  endproperty
  a_latch_vcc: assert property (p_latch_vcc) else $error("no supply regulation");
  property p_on_max;
    on_cnt <= MAX_ON_CYC + 2;
  endproperty
  a_on_max: assert property (p_on_max) else $error("on-time too long");
  property p_opc_cut;
    gate_o && cmp_i.opc_high && ce_i |=> !gate_o;
  endproperty
  a_opc_cut: assert property (p_opc_cut) else $error("pulse not cut");
  property p_opp_supply_undervoltage_lock;
    gate_o && cmp_i.opp_low && cmp_i.opp_low_100 && cmp_i.supply_undervoltage_lock && ce_i |-> ##[1:4] restart_o;
  endproperty
  a_opp_supply_undervoltage_lock: assert property (p_opp_supply_undervoltage_lock) else $error("no protect on supply_undervoltage_lock");
  property p_gate_en;
    $rose(gate_o) |-> prot_enable_o;
  endproperty
  a_gate_en: assert property (p_gate_en) else $error("gate before enable");
endmodule

bind fps_supervisor fps_supervisor_asserts #(.MAX_ON_CYC(MAX_ON_CYC)) fps_supervisor_asserts_i (
  .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cmp_i(cmp_i), .gate_o(gate_o),
  .mains_sense_pin_pull_o(mains_sense_pin_pull_o), .xcap_discharge_o(xcap_discharge_o),
  .vcc_regulate_o(vcc_regulate_o), .prot_enable_o(prot_enable_o), .brownout_o(brownout_o),
  .latched_o(latched_o), .restart_o(restart_o));

/* File: dv/fps_stage_model.sv */
`timescale 1ns/1ps
module fps_stage_model (
  // Clock
  input  wire logic            mclk_i,
  // Device side
  input  wire logic            gate_i,
  input  wire logic            pull_i,
  // Scenario controls
  input  wire logic            mains_on_i,
  input  wire logic [15:0]     ton_i,
  // Stage answers
  output logic                 demag_o,
  output logic                 valley_o,
  output logic                 opc_o,
  output fps_pkg::fps_mains_t  mains_o
);
  logic [15:0] t_on;
  logic [7:0]  t_off;
  logic [3:0]  pc;
  logic        ph;

  initial begin
    t_on = '0;
    t_off = '0;
    pc = '0;
    ph = 1'b0;
  end

  always @(posedge mclk_i) begin
    t_on <= gate_i ? t_on + 16'h0001 : 16'h0000;
    // Ringing never dies out, so valleys keep coming
    t_off <= gate_i ? 8'h00 : (t_off == 8'hFF ? 8'h10 : t_off + 8'h01);
    opc_o <= gate_i && t_on >= ton_i;
    demag_o <= !gate_i && t_off < 8'h0A;
    valley_o <= !gate_i && t_off >= 8'h0A && t_off[2:0] == 3'h2;
    pc <= pull_i ? pc + 4'h1 : 4'h0;
    mains_o.valid <= pull_i && pc == 4'h0;
    // Alternate samples give a rising crossing every other sample
    if (pull_i && pc == 4'h0) begin
      ph <= ~ph;
    end
    mains_o.above_brownin <= mains_on_i && ph;
    mains_o.above_high <= mains_on_i && ph;
    mains_o.above_brownout <= mains_on_i;
  end
endmodule

/* File: dv/fps_supervisor_tb.sv */
`timescale 1ns/1ps
module fps_supervisor_tb;
  localparam int MS = 20;
  localparam int MO = 30;
  localparam int O = 0, X = 1, B = 2, L = 3, R = 4, G = 5, P = 6;
  logic                mclk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                ce_i = 1'b1;
  logic                ton_req_i = 1'b0;
  logic                mains_on = 1'b1;
  logic [15:0]         ton = 16'h000A;
  fps_pkg::fps_cmp_t   drv = '0;
  fps_pkg::fps_cmp_t   cmp;
  fps_pkg::fps_mains_t mains;
  fps_pkg::fps_mode_t  mode;
  fps_pkg::fps_sec_t   sec;
  logic                dm, vl, oc, gate, pull, xcap, vreg, pen, bo, lat, rs, ocl;
  logic [6:0]          st;
  int                  n_fail = 0;
  int                  checks_done = 0;

  always #20 mclk_i = ~mclk_i;
  assign st = {pull, gate, rs, lat, bo, xcap, ocl};
  always_comb begin
    cmp = drv;
    cmp.demag = dm;
    cmp.valley = vl;
    cmp.opc_high = oc;
  end

  fps_supervisor #(.MS_CYC(MS), .MAX_ON_CYC(MO)) fps_supervisor_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .cmp_i(cmp), .mains_i(mains),
    .ton_req_i(ton_req_i), .osc_period_i(16'h0028), .gate_o(gate), .mains_sense_pin_pull_o(pull),
    .xcap_discharge_o(xcap), .vcc_regulate_o(vreg), .prot_enable_o(pen), .mode_o(mode),
    .section_o(sec), .brownout_o(bo), .latched_o(lat), .restart_o(rs), .ocp_limit_o(ocl));
  fps_stage_model fps_stage_model_i (
    .mclk_i(mclk_i), .gate_i(gate), .pull_i(pull), .mains_on_i(mains_on), .ton_i(ton),
    .demag_o(dm), .valley_o(vl), .opc_o(oc), .mains_o(mains));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // Wait at most lim cycles for status bit k to reach v
  task automatic wt(input int k, input logic v, input int lim);
    int i;
    i = 0;
    while (st[k] !== v && i < lim) begin
      @(negedge mclk_i);
      i++;
    end
  endtask
  task automatic ms(input int n);
    repeat (n * MS) @(negedge mclk_i);
  endtask
  task automatic rst_dut();
    @(negedge mclk_i);
    rst_i = 1'b1;
    drv = '0;
    mains_on = 1'b1;
    ton = 16'h000A;
    ton_req_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_start();
    mains_on = 1'b0;
    wt(P, 1, 2 * MS);
    chk("pull", 1, pull);
    ms(10);
    chk("gate_early", 0, gate);
    mains_on = 1'b1;
    wt(G, 1, 40 * MS);
    chk("gate_run", 1, gate);
    @(negedge mclk_i);
    chk("section_on", fps_pkg::FPS_SEC_ON, sec);
    ce_i = 1'b0;
    repeat (30) @(negedge mclk_i);
    chk("gate_frozen", 1, gate);
    ce_i = 1'b1;
    chk("mode_qr", fps_pkg::FPS_QR, mode);
    wt(G, 0, 40);
    @(negedge mclk_i);
    chk("section_demag", fps_pkg::FPS_SEC_DEMAG, sec);
  endtask
  task automatic s_brown();
    mains_on = 1'b0;
    ms(20);
    chk("bo_early", 0, bo);
    wt(B, 1, 30 * MS);
    chk("brownout", 1, bo);
    @(negedge mclk_i);
    chk("gate_bo", 0, gate);
    wt(X, 1, 20 * MS);
    chk("xcap", 1, xcap);
    mains_on = 1'b1;
    wt(G, 1, 60 * MS);
    chk("resume", 1, gate);
  endtask
  task automatic s_modes();
    fps_pkg::fps_mode_t em [3] = '{fps_pkg::FPS_DCM, fps_pkg::FPS_FREQ, fps_pkg::FPS_BURST};
    wt(G, 1, 20 * MS);
    ton_req_i = 1'b1;
    for (int i = 0; i < 3; i++) begin
      drv.f_at_max = (i == 0);
      drv.ctrl_freq_red = (i == 1);
      drv.ctrl_burst = (i == 2);
      ms(3);
      chk("mode", em[i], mode);
    end
  endtask
  task automatic s_ovp();
    drv.aux_ovp = 1'b1;
    repeat (3) begin
      wt(G, 1, 20 * MS);
      wt(G, 0, MS);
    end
    chk("ovp_early", 0, lat);
    wt(L, 1, 20 * MS);
    chk("ovp_latch", 1, lat);
    drv.aux_ovp = 1'b0;
    ms(50);
    chk("latch_hold", 1, lat);
    chk("gate_off", 0, gate);
    chk("vcc_reg", 1, vreg);
  endtask
  task automatic s_temp();
    wt(G, 1, 20 * MS);
    drv.prot_low = 1'b1;
    ms(1);
    chk("temp_early", 0, lat);
    ms(4);
    chk("temp_latch", 1, lat);
  endtask
  task automatic s_maxon();
    ton = 16'h00FF;
    wt(R, 1, 20 * MS);
    chk("maxon_restart", 1, rs);
    ms(790);
    chk("restart_hold", 1, rs);
    ton = 16'h000A;
    wt(R, 0, 20 * MS);
    chk("restart_end", 0, rs);
    wt(G, 1, 20 * MS);
    chk("gate_again", 1, gate);
  endtask
  task automatic s_opp();
    for (int i = 0; i < 2; i++) begin
      rst_dut();
      drv.ctrl_regulated = (i == 1);
      wt(G, 1, 20 * MS);
      drv.opp_low = 1'b1;
      drv.opp_low_100 = 1'b1;
      ms(i ? 190 : 35);
      chk("opp_early", 0, rs);
      wt(R, 1, 20 * MS);
      chk("opp_restart", 1, rs);
    end
  endtask
  task automatic s_opp_supply_undervoltage_lock();
    wt(G, 1, 20 * MS);
    drv.opp_low = 1'b1;
    drv.opp_low_100 = 1'b1;
    drv.supply_undervoltage_lock = 1'b1;
    wt(R, 1, 2 * MS);
    chk("opp_supply_undervoltage_lock", 1, rs);
  endtask
  task automatic s_ocp();
    wt(G, 1, 20 * MS);
    drv.ocp = 1'b1;
    wt(O, 1, 2 * MS);
    chk("ocp_flag", 1, ocl);
    ms(5);
    wt(G, 1, 2 * MS);
    chk("ocp_runs", 1, gate);
    chk("ocp_no_stop", 0, rs | lat);
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    rst_dut();
    s_start();
    s_brown();
    rst_dut();
    s_modes();
    rst_dut();
    s_ovp();
    rst_dut();
    s_temp();
    rst_dut();
    s_maxon();
    s_opp();
    rst_dut();
    s_opp_supply_undervoltage_lock();
    rst_dut();
    s_ocp();
    test_done();
  end
endmodule
